// >>> hw/pps_port_regs.sv
// module: device status and link capabilities registers of one switch port, AHB-Lite slave
`timescale 1ns/1ps

module pps_port_regs #(
   parameter int PORT_INDEX = 0
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire pps_pkg::pps_err_s errEvent,
   input wire logic auxPowerPin,
   input wire logic capsLoad,
   input wire pps_pkg::pps_caps_s capsLoadValue,
   output pps_pkg::pps_err_s errReport,
   output logic irq
);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   generate
      if (PORT_INDEX < 0 || PORT_INDEX > 2)
      begin : g_bad_port
         $error("PORT_INDEX must be 0, 1 or 2");
      end
   endgenerate

   // ----------------------------------------------------------------
   // per-port constants
   // ----------------------------------------------------------------
   localparam logic [5:0] WIDTH_RST = (PORT_INDEX == 0) ? pps_pkg::WIDTH_X2 : pps_pkg::WIDTH_X1;
   localparam logic BW_NOTICE = (PORT_INDEX != 0);
   localparam logic [7:0] PORT_NUM_RST = 8'(PORT_INDEX);

   localparam pps_pkg::pps_caps_s CAPS_RST = '{
      aspm: pps_pkg::ASPM_RST,
      l0sLat: pps_pkg::L0S_LAT_RST,
      l1Lat: pps_pkg::L1_LAT_RST,
      portNum: PORT_NUM_RST
   };

   localparam pps_pkg::pps_state_s STATE_RST = '{
      rdWait: 1'b0,
      wrPend: 1'b0,
      addr: '0,
      hrdata: 32'h0000_0000,
      hreadyout: 1'b1,
      ctrlEnable: pps_pkg::ERR_RST,
      errFlags: pps_pkg::ERR_RST,
      auxMeta: pps_pkg::AUX_RST,
      auxSeen: pps_pkg::AUX_RST,
      caps: CAPS_RST,
      irqStatus: pps_pkg::ERR_RST,
      irqEnable: pps_pkg::ERR_RST,
      irq: 1'b0,
      errReport: pps_pkg::ERR_RST
   };

   pps_pkg::pps_state_s s;
   pps_pkg::pps_state_s next_s;

   // ----------------------------------------------------------------
   // read words
   // ----------------------------------------------------------------
   logic [31:0] statusWord;
   logic [31:0] capsWord;
   logic [31:0] readWord;

   always_comb
   begin
      statusWord = 32'h0000_0000;
      statusWord[pps_pkg::CTRL_EN_LSB +: 4] = s.ctrlEnable;
      statusWord[pps_pkg::STAT_ERR_LSB +: 4] = s.errFlags;
      statusWord[pps_pkg::STAT_AUX_BIT] = s.auxSeen;
      statusWord[pps_pkg::STAT_PEND_BIT] = pps_pkg::PEND_VALUE;

      capsWord = 32'h0000_0000;
      capsWord[pps_pkg::CAP_SPEED_LSB +: 4] = pps_pkg::SPEED_5G0;
      capsWord[pps_pkg::CAP_WIDTH_LSB +: 6] = WIDTH_RST;
      capsWord[pps_pkg::CAP_ASPM_LSB +: 2] = s.caps.aspm;
      capsWord[pps_pkg::CAP_L0S_LSB +: 3] = s.caps.l0sLat;
      capsWord[pps_pkg::CAP_L1_LSB +: 3] = s.caps.l1Lat;
      capsWord[pps_pkg::CAP_DLL_RPT_BIT] = pps_pkg::DLL_RPT_RST;
      capsWord[pps_pkg::CAP_BW_NOTICE_BIT] = BW_NOTICE;
      capsWord[pps_pkg::CAP_PORT_LSB +: 8] = s.caps.portNum;

      case (s.addr)
         pps_pkg::OFS_DEV_CTRL_STATUS: readWord = statusWord;
         pps_pkg::OFS_LINK_CAPS: readWord = capsWord;
         pps_pkg::OFS_IRQ_STATUS: readWord = {28'h0000000, s.irqStatus};
         pps_pkg::OFS_IRQ_ENABLE: readWord = {28'h0000000, s.irqEnable};
         default: readWord = pps_pkg::UNMAPPED_READ;
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic addrPhase;
   logic wrStatus;
   logic wrCtrl;
   logic wrEnable;
   logic wrClear;
   pps_pkg::pps_err_s errClear;
   pps_pkg::pps_err_s irqClear;

   always_comb
   begin
      next_s = s;
      addrPhase = hsel && hready && htrans[1];
      wrStatus = s.wrPend && (s.addr == pps_pkg::OFS_DEV_CTRL_STATUS);
      wrCtrl = wrStatus;
      wrEnable = s.wrPend && (s.addr == pps_pkg::OFS_IRQ_ENABLE);
      wrClear = s.wrPend && (s.addr == pps_pkg::OFS_IRQ_CLEAR);
      errClear = wrStatus ? pps_pkg::pps_err_s'(hwdata[pps_pkg::STAT_ERR_LSB +: 4]) : pps_pkg::ERR_RST;
      irqClear = wrClear ? pps_pkg::pps_err_s'(hwdata[3:0]) : pps_pkg::ERR_RST;

      // aux pin crosses in from outside: two flops
      next_s.auxMeta = auxPowerPin;
      next_s.auxSeen = s.auxMeta;

      // set wins over a write-one clear in the same cycle
      next_s.errFlags = pps_pkg::pps_err_s'((s.errFlags & ~errClear) | errEvent);
      // logging ignores the enables; only the report path looks at them
      next_s.errReport = pps_pkg::pps_err_s'(errEvent & s.ctrlEnable);
      next_s.irqStatus = pps_pkg::pps_err_s'((s.irqStatus & ~irqClear) | errEvent);

      if (wrCtrl)
      begin
         next_s.ctrlEnable = pps_pkg::pps_err_s'(hwdata[pps_pkg::CTRL_EN_LSB +: 4]);
      end
      if (wrEnable)
      begin
         next_s.irqEnable = pps_pkg::pps_err_s'(hwdata[3:0]);
      end

      // caps are read-only from the bus; only the management load changes them
      if (capsLoad)
      begin
         next_s.caps = capsLoadValue;
      end

      next_s.irq = |(next_s.irqStatus & next_s.irqEnable);

      // bus: writes are zero-wait, reads take one wait state
      next_s.wrPend = 1'b0;
      if (s.rdWait)
      begin
         next_s.hrdata = readWord;
         next_s.hreadyout = 1'b1;
         next_s.rdWait = 1'b0;
      end
      else if (addrPhase)
      begin
         next_s.addr = {haddr[pps_pkg::ADDR_W-1:2], 2'b00};
         next_s.wrPend = hwrite;
         if (!hwrite)
         begin
            next_s.rdWait = 1'b1;
            next_s.hreadyout = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= STATE_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign hrdata = s.hrdata;
   assign hreadyout = s.hreadyout;
   // slave never errors, so the response is fixed
   assign hresp = pps_pkg::HRESP_OKAY;
   assign errReport = s.errReport;
   assign irq = s.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   property p_cor_set;
      errEvent.correctable |=> s.errFlags.correctable;
   endproperty
   a_cor_set: assert property (p_cor_set) else $error("correctable flag not set");

   property p_nonfatal_set;
      errEvent.nonFatal |=> s.errFlags.nonFatal;
   endproperty
   a_nonfatal_set: assert property (p_nonfatal_set) else $error("non-fatal flag not set");

   property p_fatal_set;
      errEvent.fatal |=> s.errFlags.fatal;
   endproperty
   a_fatal_set: assert property (p_fatal_set) else $error("fatal flag not set");

   property p_unsup_set;
      errEvent.unsupported |=> s.errFlags.unsupported;
   endproperty
   a_unsup_set: assert property (p_unsup_set) else $error("unsupported flag not set");

   property p_log_unmasked;
      (s.ctrlEnable == pps_pkg::ERR_RST && errEvent != pps_pkg::ERR_RST)
         |=> (s.errFlags != pps_pkg::ERR_RST) && (s.errReport == pps_pkg::ERR_RST);
   endproperty
   a_log_unmasked: assert property (p_log_unmasked) else $error("masked error not logged");

   property p_aux_follow;
      auxPowerPin [*3] |-> s.auxSeen == auxPowerPin;
   endproperty
   a_aux_follow: assert property (p_aux_follow) else $error("aux power bit does not follow pin");

   property p_status_read;
      (s.hreadyout && $past(s.rdWait) && s.addr == pps_pkg::OFS_DEV_CTRL_STATUS)
         |-> !hrdata[pps_pkg::STAT_PEND_BIT] && hrdata[31:22] == 10'h000
             && hrdata[pps_pkg::STAT_ERR_LSB +: 4] == $past(s.errFlags);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read word wrong");

   property p_caps_read;
      (s.hreadyout && $past(s.rdWait) && s.addr == pps_pkg::OFS_LINK_CAPS)
         |-> hrdata[pps_pkg::CAP_SPEED_LSB +: 4] == pps_pkg::SPEED_5G0
             && hrdata[pps_pkg::CAP_WIDTH_LSB +: 6] == WIDTH_RST
             && !hrdata[pps_pkg::CAP_DLL_RPT_BIT]
             && hrdata[pps_pkg::CAP_BW_NOTICE_BIT] == BW_NOTICE;
   endproperty
   a_caps_read: assert property (p_caps_read) else $error("fixed capability fields wrong");

   property p_caps_load;
      capsLoad |=> s.caps == $past(capsLoadValue);
   endproperty
   a_caps_load: assert property (p_caps_load) else $error("management load not taken");

   property p_caps_hold;
      !capsLoad |=> $stable(s.caps);
   endproperty
   a_caps_hold: assert property (p_caps_hold) else $error("capabilities changed without load");

   property p_ctrl_write;
      wrCtrl |=> s.ctrlEnable == $past(hwdata[3:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("enable write not stored");

   property p_flag_fall;
      $fell(s.errFlags.fatal) |-> $past(wrStatus && hwdata[pps_pkg::STAT_ERR_LSB + 2]);
   endproperty
   a_flag_fall: assert property (p_flag_fall) else $error("fatal flag cleared without write one");

   property p_read_wait;
      (addrPhase && !hwrite && !s.rdWait) |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

   property p_irq_level;
      irq == |(s.irqStatus & s.irqEnable);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

   property p_cor_fall;
      $fell(s.errFlags.correctable) |-> $past(wrStatus && hwdata[pps_pkg::STAT_ERR_LSB]);
   endproperty
   a_cor_fall: assert property (p_cor_fall) else $error("correctable flag cleared without write one");

   property p_nonfatal_fall;
      $fell(s.errFlags.nonFatal) |-> $past(wrStatus && hwdata[pps_pkg::STAT_ERR_LSB + 1]);
   endproperty
   a_nonfatal_fall: assert property (p_nonfatal_fall) else $error("non-fatal flag cleared without write one");

   property p_unsup_fall;
      $fell(s.errFlags.unsupported) |-> $past(wrStatus && hwdata[pps_pkg::STAT_ERR_LSB + 3]);
   endproperty
   a_unsup_fall: assert property (p_unsup_fall) else $error("unsupported flag cleared without write one");

   property p_report_pass;
      (errEvent & s.ctrlEnable) != pps_pkg::ERR_RST |=> errReport == $past(errEvent & s.ctrlEnable);
   endproperty
   a_report_pass: assert property (p_report_pass) else $error("enabled error not reported");

   property p_report_quiet;
      (errEvent & s.ctrlEnable) == pps_pkg::ERR_RST |=> errReport == pps_pkg::ERR_RST;
   endproperty
   a_report_quiet: assert property (p_report_quiet) else $error("report without enabled error");

   property p_ctrl_hold;
      !wrCtrl |=> $stable(s.ctrlEnable);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("enables changed without write");

   property p_status_fields;
      (s.hreadyout && $past(s.rdWait) && s.addr == pps_pkg::OFS_DEV_CTRL_STATUS)
         |-> hrdata[pps_pkg::CTRL_EN_LSB +: 4] == $past(s.ctrlEnable) && hrdata[15:4] == 12'h000
             && hrdata[pps_pkg::STAT_AUX_BIT] == $past(s.auxSeen);
   endproperty
   a_status_fields: assert property (p_status_fields) else $error("status low fields wrong");

   property p_caps_loadable;
      (s.hreadyout && $past(s.rdWait) && s.addr == pps_pkg::OFS_LINK_CAPS)
         |-> hrdata[pps_pkg::CAP_ASPM_LSB +: 2] == $past(s.caps.aspm)
             && hrdata[pps_pkg::CAP_L0S_LSB +: 3] == $past(s.caps.l0sLat)
             && hrdata[pps_pkg::CAP_L1_LSB +: 3] == $past(s.caps.l1Lat)
             && hrdata[pps_pkg::CAP_PORT_LSB +: 8] == $past(s.caps.portNum)
             && hrdata[19:18] == 2'h0 && hrdata[23:22] == 2'h0;
   endproperty
   a_caps_loadable: assert property (p_caps_loadable) else $error("loadable capability fields wrong");

   property p_unmapped_read;
      (s.hreadyout && $past(s.rdWait)
         && s.addr != pps_pkg::OFS_DEV_CTRL_STATUS && s.addr != pps_pkg::OFS_LINK_CAPS
         && s.addr != pps_pkg::OFS_IRQ_STATUS && s.addr != pps_pkg::OFS_IRQ_ENABLE)
         |-> hrdata == pps_pkg::UNMAPPED_READ;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

   property p_read_hold;
      !s.rdWait |=> $stable(hrdata);
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("read data changed outside a read");

   property p_write_nowait;
      (addrPhase && hwrite && !s.rdWait) |=> hreadyout;
   endproperty
   a_write_nowait: assert property (p_write_nowait) else $error("write inserted a wait state");

   property p_irq_status_set;
      errEvent != pps_pkg::ERR_RST |=> (s.irqStatus & $past(errEvent)) == $past(errEvent);
   endproperty
   a_irq_status_set: assert property (p_irq_status_set) else $error("interrupt status not set");

   property p_irq_enable_write;
      wrEnable |=> s.irqEnable == $past(hwdata[3:0]);
   endproperty
   a_irq_enable_write: assert property (p_irq_enable_write) else $error("interrupt enable write not stored");

   property p_irq_fall;
      $fell(s.irqStatus.fatal) |-> $past(wrClear && hwdata[2]);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt status cleared without write one");

   property p_irq_set;
      (errEvent.fatal && s.irqEnable.fatal && !wrEnable) |=> irq;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("enabled event did not raise interrupt");

endmodule // pps_port_regs

// >>> hw/pps_pkg.sv
// package: offsets, field layout, reset values and carrier types of the port register bank
package pps_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte addresses, low 12 bits decoded)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_DEV_CTRL_STATUS = 12'h0c8;
   localparam logic [11:0] OFS_LINK_CAPS = 12'h0cc;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h100;
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h104;
   localparam logic [11:0] OFS_IRQ_CLEAR = 12'h108;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_EN_LSB = 0;
   localparam int STAT_ERR_LSB = 16;
   localparam int STAT_AUX_BIT = 20;
   localparam int STAT_PEND_BIT = 21;
   localparam int CAP_SPEED_LSB = 0;
   localparam int CAP_WIDTH_LSB = 4;
   localparam int CAP_ASPM_LSB = 10;
   localparam int CAP_L0S_LSB = 12;
   localparam int CAP_L1_LSB = 15;
   localparam int CAP_DLL_RPT_BIT = 20;
   localparam int CAP_BW_NOTICE_BIT = 21;
   localparam int CAP_PORT_LSB = 24;

   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [3:0] SPEED_2G5 = 4'h1;
   localparam logic [3:0] SPEED_5G0 = 4'h2;
   localparam logic [5:0] WIDTH_X2 = 6'h02;
   localparam logic [5:0] WIDTH_X1 = 6'h01;
   localparam logic [1:0] ASPM_RST = 2'h0;
   localparam logic [2:0] L0S_LAT_RST = 3'h3;
   localparam logic [2:0] L1_LAT_RST = 3'h0;
   localparam logic DLL_RPT_RST = 1'b0;
   localparam logic PEND_VALUE = 1'b0;
   localparam logic AUX_RST = 1'b1;
   localparam logic [3:0] ERR_RST = 4'h0;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   localparam logic HRESP_OKAY = 1'b0;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic unsupported;
      logic fatal;
      logic nonFatal;
      logic correctable;
   } pps_err_s;

   typedef struct packed {
      logic [1:0] aspm;
      logic [2:0] l0sLat;
      logic [2:0] l1Lat;
      logic [7:0] portNum;
   } pps_caps_s;

   typedef struct packed {
      logic rdWait;
      logic wrPend;
      logic [ADDR_W-1:0] addr;
      logic [31:0] hrdata;
      logic hreadyout;
      pps_err_s ctrlEnable;
      pps_err_s errFlags;
      logic auxMeta;
      logic auxSeen;
      pps_caps_s caps;
      pps_err_s irqStatus;
      pps_err_s irqEnable;
      logic irq;
      pps_err_s errReport;
   } pps_state_s;

endpackage

// >>> bench/tb_pps_port_regs.sv
// testbench: bus, error flag, interrupt and capability checks of a downstream port; reset capability check of the upstream port
`timescale 1ns/1ps

module tb_pps_port_regs;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic mclk;
   logic rst_n;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   pps_pkg::pps_err_s errEvent;
   logic auxPowerPin;
   logic capsLoad;
   pps_pkg::pps_caps_s capsLoadValue;
   pps_pkg::pps_err_s errReport;
   logic irq;
   logic [31:0] hrdata0;
   logic hreadyout0;
   logic [31:0] rd;
   logic [31:0] rd0;
   logic [3:0] rep;
   int n_fail = 0;
   int num_checks = 0;

   // port 1: downstream, so width and bandwidth notice differ from port 0
   pps_port_regs #(.PORT_INDEX(1)) dut (
      .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .errEvent(errEvent),
      .auxPowerPin(auxPowerPin), .capsLoad(capsLoad), .capsLoadValue(capsLoadValue),
      .errReport(errReport), .irq(irq));

   // port 0: upstream, shares every input but hready (fed from its own hreadyout0) so its fixed caps can be read alongside
   pps_port_regs #(.PORT_INDEX(0)) dut0 (
      .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout0), .hwdata(hwdata),
      .hrdata(hrdata0), .hreadyout(hreadyout0), .hresp(), .errEvent(errEvent),
      .auxPowerPin(auxPowerPin), .capsLoad(capsLoad), .capsLoadValue(capsLoadValue),
      .errReport(), .irq());

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task report_and_stop;
      if (n_fail == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // single word transfer; waits on hready, never on a fixed count
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge mclk);
      while (hreadyout !== 1'b1)
         @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge mclk);
      while (hreadyout !== 1'b1)
         @(posedge mclk);
      rd = hrdata;
      rd0 = hrdata0;
   endtask

   task rdc(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   // one-cycle event; rep holds the report seen one cycle later
   task pulse(input logic [3:0] v);
      @(posedge mclk);
      errEvent <= v;
      @(posedge mclk);
      errEvent <= 4'h0;
      @(posedge mclk);
      rep = errReport;
   endtask

   function automatic logic [31:0] st(input logic [3:0] en, input logic [3:0] f, input logic aux);
      return {10'h000, 1'b0, aux, f, 12'h000, en};
   endfunction

   function automatic logic [31:0] cap(input logic [1:0] as, input logic [2:0] l0, input logic [2:0] l1,
                                       input logic [7:0] pn);
      return {pn, 2'h0, 1'b1, 1'b0, 2'h0, l1, l0, as, 6'h01, 4'h2};
   endfunction

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset;
      rdc(12'h0c8, st(4'h0, 4'h0, 1'b1));
      rdc(12'h0cc, cap(2'h0, 3'h3, 3'h0, 8'h01));
      chk(rd0, {8'h00, 2'h0, 1'b0, 1'b0, 2'h0, 3'h0, 3'h3, 2'h0, 6'h02, 4'h2});
      rdc(12'h100, 32'h0000_0000);
   endtask

   task t_flags;
      for (int i = 0; i < 4; i++)
      begin
         pulse(4'h1 << i);
         chk(rep, 4'h0);
         rdc(12'h0c8, st(4'h0, 4'h1 << i, 1'b1));
         bus(1'b1, 12'h0c8, 32'h0000_0000);
         rdc(12'h0c8, st(4'h0, 4'h1 << i, 1'b1));
         bus(1'b1, 12'h0c8, 32'h0001_0000 << i);
         rdc(12'h0c8, st(4'h0, 4'h0, 1'b1));
      end
      bus(1'b1, 12'h108, 32'h0000_000f);
   endtask

   task t_ro;
      bus(1'b1, 12'h0c8, 32'hfff0_fff0);
      rdc(12'h0c8, st(4'h0, 4'h0, 1'b1));
      bus(1'b1, 12'h0cc, 32'hffff_ffff);
      rdc(12'h0cc, cap(2'h0, 3'h3, 3'h0, 8'h01));
      bus(1'b1, 12'h0f0, 32'hffff_ffff);
      rdc(12'h0f0, 32'h0000_0000);
   endtask

   task t_report;
      bus(1'b1, 12'h0c8, 32'h0000_000f);
      rdc(12'h0c8, st(4'hf, 4'h0, 1'b1));
      pulse(4'h4);
      chk(rep, 4'h4);
      rdc(12'h0c8, st(4'hf, 4'h4, 1'b1));
      bus(1'b1, 12'h0c8, 32'h0004_0000);
      rdc(12'h0c8, st(4'h0, 4'h0, 1'b1));
      bus(1'b1, 12'h108, 32'h0000_000f);
   endtask

   // masked event must not raise irq; enabled one must
   task t_irq;
      bus(1'b1, 12'h104, 32'h0000_0004);
      pulse(4'h1);
      @(posedge mclk);
      chk(irq, 1'b0);
      pulse(4'h4);
      @(posedge mclk);
      chk(irq, 1'b1);
      rdc(12'h100, 32'h0000_0005);
      bus(1'b1, 12'h108, 32'h0000_0004);
      rdc(12'h100, 32'h0000_0001);
      chk(irq, 1'b0);
      bus(1'b1, 12'h108, 32'h0000_0001);
      rdc(12'h100, 32'h0000_0000);
      bus(1'b1, 12'h0c8, 32'h000f_0000);
      rdc(12'h0c8, st(4'h0, 4'h0, 1'b1));
   endtask

   task t_load;
      @(posedge mclk);
      capsLoad <= 1'b1;
      capsLoadValue <= '{2'h3, 3'h5, 3'h7, 8'h9a};
      @(posedge mclk);
      capsLoad <= 1'b0;
      rdc(12'h0cc, cap(2'h3, 3'h5, 3'h7, 8'h9a));
   endtask

   // pin passes a two-flop synchroniser, so allow a few edges
   task t_aux;
      @(posedge mclk);
      auxPowerPin <= 1'b0;
      repeat (4) @(posedge mclk);
      rdc(12'h0c8, st(4'h0, 4'h0, 1'b0));
      auxPowerPin <= 1'b1;
      chk(hresp, 1'b0);
   endtask

   // ----------------------------------------------------------------
   // clock, main sequence, watchdog
   // ----------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   initial
   begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      errEvent = 4'h0;
      auxPowerPin = 1'b1;
      capsLoad = 1'b0;
      capsLoadValue = 16'h0000;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_flags();
      t_ro();
      t_report();
      t_irq();
      t_load();
      t_aux();
      report_and_stop();
   end

   initial
   begin
      #(25 * 5000);
      n_fail++;
      report_and_stop();
   end
endmodule // tb_pps_port_regs
